//--- verilog/prl_loader.sv
// Program store loader: fills the RAM from a serial EEPROM at boot
`timescale 1ns/1ps
`default_nettype none

module prl_loader #(
   parameter int WORDS = prl_pkg::ROM_WORDS,
   parameter int QUARTER_CYC = prl_pkg::SCL_QUARTER_CYC
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   // Reload pin
   input wire logic reload_start_in_i,
   // EEPROM link
   output logic scl_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Status to the chip
   output logic load_err_o,
   output logic sys_reset_o,
   output logic cpu_run_o,
   // CPU fetch port
   input wire logic [prl_pkg::ADDR_W-1:0] fetch_addr_i,
   output logic [prl_pkg::WORD_W-1:0] fetch_data_o,
   output logic [prl_pkg::ADDR_W-1:0] boot_addr_o,
   input wire logic [3:0] irq_num_i,
   output logic [prl_pkg::ADDR_W-1:0] vec_addr_o
);

   localparam int TW = $clog2(QUARTER_CYC + 1);
   localparam logic [13:0] IMG_BYTES = 14'(2 * WORDS);
   localparam logic [13:0] TOT_BYTES = 14'(2 * WORDS + 1);
   localparam logic [13:0] LAST_WORD = 14'(prl_pkg::ROM_WORDS - 1);

   // WORDS sets the image length; the store itself is always full size
   if (WORDS < 1 || WORDS > prl_pkg::ROM_WORDS ||
       QUARTER_CYC < 2) begin : g_bad
      $error("prl_loader: unsupported image size or SCL quarter count");
   end

   // SCL and SDA levels for a state and bit phase: {scl, sda_oe}
   function automatic logic [1:0] bus_lvl(input prl_pkg::prl_state_t st,
                                          input logic [1:0] ph,
                                          input logic bitv);
      logic hi;
      hi = (ph == 2'h1) || (ph == 2'h2);
      case (st)
         prl_pkg::S_START: bus_lvl = {hi, ph[1]};
         prl_pkg::S_STOP: bus_lvl = {ph != 2'h0, ~ph[1]};
         prl_pkg::S_TX, prl_pkg::S_RXACK: bus_lvl = {hi, ~bitv};
         prl_pkg::S_TXACK, prl_pkg::S_RX: bus_lvl = {hi, 1'b0};
         default: bus_lvl = 2'b10;
      endcase
   endfunction

   // Pin synchronisers
   logic rl_m_q, rl_s_q, rl_p_q, sda_m_q, sda_s_q;
   logic rl_m_d, rl_s_d, rl_p_d, sda_m_d, sda_s_d;
   logic reload_rise;

   always_comb begin
      rl_m_d = reload_start_in_i;
      rl_s_d = rl_m_q;
      rl_p_d = rl_s_q;
      sda_m_d = sda_i;
      sda_s_d = sda_m_q;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         rl_m_q <= 1'b0;
         rl_s_q <= 1'b0;
         rl_p_q <= 1'b0;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         rl_m_q <= rl_m_d;
         rl_s_q <= rl_s_d;
         rl_p_q <= rl_p_d;
         sda_m_q <= sda_m_d;
         sda_s_q <= sda_s_d;
      end
   end

   assign reload_rise = rl_s_q & ~rl_p_q;

   // Quarter-bit enable divider
   logic [TW-1:0] tcnt_q, tcnt_d;
   logic tick;

   assign tick = (tcnt_q == TW'(QUARTER_CYC - 1));

   always_comb begin
      tcnt_d = tick ? '0 : tcnt_q + TW'(1);
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         tcnt_q <= '0;
      end else begin
         tcnt_q <= tcnt_d;
      end
   end

   // Loader state
   prl_pkg::prl_state_t state_q, state_d;
   logic [1:0] ph_q, ph_d, step_q, step_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d, sum_q, sum_d;
   logic [13:0] cnt_q, cnt_d;
   logic [3:0] hi_q, hi_d;
   logic scl_q, scl_d, oe_q, oe_d, err_q, err_d;
   logic we_q, we_d, run_q, run_d, rst_q, rst_d, epin_q, epin_d;
   logic [11:0] wa_q, wa_d, wd_q, wd_d;
   logic nack;

   always_comb begin
      state_d = state_q;
      ph_d = ph_q;
      step_d = step_q;
      bit_d = bit_q;
      sh_d = sh_q;
      sum_d = sum_q;
      cnt_d = cnt_q;
      hi_d = hi_q;
      err_d = err_q;
      we_d = 1'b0;
      wa_d = wa_q;
      wd_d = wd_q;
      if (reload_rise && (state_q == prl_pkg::S_DONE ||
                          state_q == prl_pkg::S_ERR)) begin
         state_d = prl_pkg::S_INIT;
         cnt_d = '0;
         err_d = 1'b0;
      end else if (state_q == prl_pkg::S_INIT) begin
         // Clear the store before loading
         we_d = 1'b1;
         wa_d = cnt_q[11:0];
         wd_d = '0;
         cnt_d = cnt_q + 14'h0001;
         if (cnt_q == LAST_WORD) begin
            state_d = prl_pkg::S_START;
            cnt_d = '0;
            step_d = prl_pkg::STEP_CTRL_WR;
            sum_d = '0;
            ph_d = 2'h0;
         end
      end else if (tick) begin
         ph_d = ph_q + 2'h1;
         case (state_q)
            prl_pkg::S_START: begin
               if (ph_q == 2'h3) begin
                  // Write the start address, then restart for reading
                  sh_d = {prl_pkg::EE_DEV_ADDR,
                          step_q == prl_pkg::STEP_CTRL_RD};
                  bit_d = 3'h7;
                  state_d = prl_pkg::S_TX;
               end
            end
            prl_pkg::S_TX: begin
               if (ph_q == 2'h3) begin
                  sh_d = {sh_q[6:0], 1'b0};
                  bit_d = bit_q - 3'h1;
                  if (bit_q == 3'h0) begin
                     state_d = prl_pkg::S_TXACK;
                  end
               end
            end
            prl_pkg::S_TXACK: begin
               if (ph_q == 2'h2) begin
                  sh_d[0] = sda_s_q;
               end else if (ph_q == 2'h3) begin
                  bit_d = 3'h7;
                  if (sh_q[0]) begin
                     err_d = 1'b1;
                     state_d = prl_pkg::S_STOP;
                  end else begin
                     case (step_q)
                        prl_pkg::STEP_CTRL_WR: begin
                           sh_d = prl_pkg::EE_ADDR_HI;
                           state_d = prl_pkg::S_TX;
                        end
                        prl_pkg::STEP_ADDR_HI: begin
                           sh_d = prl_pkg::EE_ADDR_LO;
                           state_d = prl_pkg::S_TX;
                        end
                        prl_pkg::STEP_ADDR_LO: begin
                           state_d = prl_pkg::S_START;
                        end
                        default: begin
                           state_d = prl_pkg::S_RX;
                        end
                     endcase
                     step_d = step_q + 2'h1;
                  end
               end
            end
            prl_pkg::S_RX: begin
               if (ph_q == 2'h2) begin
                  sh_d = {sh_q[6:0], sda_s_q};
               end else if (ph_q == 2'h3) begin
                  bit_d = bit_q - 3'h1;
                  if (bit_q == 3'h0) begin
                     // Check each byte as it arrives
                     state_d = prl_pkg::S_RXACK;
                     cnt_d = cnt_q + 14'h0001;
                     sum_d = sum_q + sh_q;
                     if (cnt_q < IMG_BYTES) begin
                        if (!cnt_q[0]) begin
                           hi_d = sh_q[3:0];
                           err_d = (sh_q[7:4] != 4'h0);
                        end else begin
                           // Only program words reach the store
                           we_d = 1'b1;
                           wa_d = cnt_q[12:1];
                           wd_d = {hi_q, sh_q};
                        end
                     end
                  end
               end
            end
            prl_pkg::S_RXACK: begin
               if (ph_q == 2'h3) begin
                  bit_d = 3'h7;
                  state_d = (err_q || cnt_q == TOT_BYTES) ?
                            prl_pkg::S_STOP : prl_pkg::S_RX;
               end
            end
            prl_pkg::S_STOP: begin
               if (ph_q == 2'h3) begin
                  if (err_q || sum_q != 8'h00) begin
                     err_d = 1'b1;
                     state_d = prl_pkg::S_ERR;
                  end else begin
                     state_d = prl_pkg::S_DONE;
                  end
               end
            end
            default: begin
               ph_d = ph_q;
            end
         endcase
      end
      // Loader owns the link clock, SDA is open drain
      nack = err_d || (cnt_d == TOT_BYTES);
      {scl_d, oe_d} = bus_lvl(state_d, ph_d,
                              (state_d == prl_pkg::S_RXACK) ?
                              nack : sh_d[7]);
      run_d = (state_d == prl_pkg::S_DONE);
      rst_d = (state_d != prl_pkg::S_DONE);
      epin_d = (state_d == prl_pkg::S_ERR);
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         state_q <= prl_pkg::S_INIT;
         ph_q <= 2'h0;
         step_q <= 2'h0;
         bit_q <= 3'h7;
         sh_q <= 8'h00;
         sum_q <= 8'h00;
         cnt_q <= 14'h0000;
         hi_q <= 4'h0;
         err_q <= 1'b0;
         we_q <= 1'b0;
         wa_q <= 12'h000;
         wd_q <= 12'h000;
         scl_q <= 1'b1;
         oe_q <= 1'b0;
         run_q <= 1'b0;
         rst_q <= 1'b1;
         epin_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ph_q <= ph_d;
         step_q <= step_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         sum_q <= sum_d;
         cnt_q <= cnt_d;
         hi_q <= hi_d;
         err_q <= err_d;
         we_q <= we_d;
         wa_q <= wa_d;
         wd_q <= wd_d;
         scl_q <= scl_d;
         oe_q <= oe_d;
         run_q <= run_d;
         rst_q <= rst_d;
         epin_q <= epin_d;
      end
   end

   // Interrupt vector address within page 1
   logic [11:0] vec_q, vec_d;

   always_comb begin
      vec_d = {prl_pkg::VEC_PAGE, 4'h0,
               (irq_num_i == 4'h0) ? prl_pkg::VEC_FIRST : irq_num_i};
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         vec_q <= {prl_pkg::VEC_PAGE, 4'h0, prl_pkg::VEC_FIRST};
      end else begin
         vec_q <= vec_d;
      end
   end

   // Program store
   prl_mem #(
      .DEPTH(prl_pkg::ROM_WORDS),
      .WIDTH(prl_pkg::WORD_W),
      .AW(prl_pkg::ADDR_W)
   ) u_mem (
      .sys_clk_i(sys_clk_i),
      .wr_en_i(we_q),
      .wr_addr_i(wa_q),
      .wr_data_i(wd_q),
      .rd_addr_i(fetch_addr_i),
      .rd_data_o(fetch_data_o)
   );

   // Outputs
   assign scl_o = scl_q;
   assign sda_o = 1'b0;
   assign sda_oe_o = oe_q;
   assign load_err_o = epin_q;
   assign sys_reset_o = rst_q;
   assign cpu_run_o = run_q;
   assign vec_addr_o = vec_q;
   assign boot_addr_o = {prl_pkg::BOOT_PAGE, prl_pkg::BOOT_STEP};

   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   chk_run_reset_excl: assert property (
      sys_reset_o == !cpu_run_o)
      else $error("system reset and CPU run overlap");

   chk_err_no_run: assert property (
      load_err_o |-> (sys_reset_o && !cpu_run_o && scl_q && !oe_q))
      else $error("error state lets CPU run or drives the link");

   chk_reload_restart: assert property (
      (cpu_run_o && reload_rise) |=> (!cpu_run_o && sys_reset_o)
      ##1 (we_q && wd_q == 12'h000))
      else $error("reload pulse did not restart the download");

   chk_init_clear: assert property (
      (state_q == prl_pkg::S_INIT) |=> (we_q && wd_q == 12'h000 &&
                                        wa_q == $past(cnt_q[11:0])))
      else $error("store not cleared before loading");

   chk_sda_scl_low: assert property (
      ($changed(oe_q) && scl_q && $past(scl_q)) |->
      (state_q == prl_pkg::S_START || state_q == prl_pkg::S_STOP))
      else $error("SDA moved while SCL high outside start or stop");

   chk_word_write: assert property (
      (state_q == prl_pkg::S_RX && tick && ph_q == 2'h3 &&
       bit_q == 3'h0 && cnt_q[0] && cnt_q < IMG_BYTES) |=>
      (we_q && wd_q == {$past(hi_q), $past(sh_q)} &&
       wa_q == $past(cnt_q[12:1])))
      else $error("received word not written to its step");

   chk_sum_error: assert property (
      (state_q == prl_pkg::S_STOP && tick && ph_q == 2'h3 &&
       sum_q != 8'h00) |=> load_err_o ##1 load_err_o)
      else $error("bad checksum did not raise the error pin");

   chk_vec_page: assert property (
      (irq_num_i != 4'h0) |=> (vec_addr_o[11:4] == 8'h10 &&
                               vec_addr_o[3:0] == $past(irq_num_i)))
      else $error("vector address outside page 1 steps 01H-0FH");

   chk_clean_run: assert property (
      (state_q == prl_pkg::S_STOP && tick && ph_q == 2'h3 &&
       !err_q && sum_q == 8'h00) |=> cpu_run_o && !load_err_o)
      else $error("clean load did not release the CPU");

endmodule // prl_loader

`default_nettype wire

//--- verilog/prl_pkg.sv
// Shared constants and types of the program store serial loader
package prl_pkg;

   // Program store geometry
   localparam int ROM_WORDS = 4096;
   localparam int WORD_W = 12;
   localparam int ADDR_W = 12;
   localparam int PAGE_W = 4;
   localparam int STEP_W = 8;

   // Fixed program addresses
   localparam logic [3:0] BOOT_PAGE = 4'h1;
   localparam logic [7:0] BOOT_STEP = 8'h00;
   localparam logic [3:0] VEC_PAGE = 4'h1;
   localparam logic [3:0] VEC_FIRST = 4'h1;

   // EEPROM link: device code and start address of the image
   localparam logic [6:0] EE_DEV_ADDR = 7'h50;
   localparam logic [7:0] EE_ADDR_HI = 8'h00;
   localparam logic [7:0] EE_ADDR_LO = 8'h00;

   // Command steps before the read phase
   localparam logic [1:0] STEP_CTRL_WR = 2'h0;
   localparam logic [1:0] STEP_ADDR_HI = 2'h1;
   localparam logic [1:0] STEP_ADDR_LO = 2'h2;
   localparam logic [1:0] STEP_CTRL_RD = 2'h3;

   // Link timing: SCL period, one quarter per bit phase, rounded up
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCL_PERIOD_NS = 2500;
   localparam int SCL_QUARTER_CYC =
      (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Loader states
   typedef enum logic [3:0] {
      S_INIT  = 4'h0,
      S_START = 4'h1,
      S_TX    = 4'h2,
      S_TXACK = 4'h3,
      S_RX    = 4'h4,
      S_RXACK = 4'h5,
      S_STOP  = 4'h6,
      S_DONE  = 4'h7,
      S_ERR   = 4'h8
   } prl_state_t;

endpackage

//--- verilog/prl_mem.sv
// Program store RAM: one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none

module prl_mem #(
   parameter int DEPTH = 4096,
   parameter int WIDTH = 12,
   parameter int AW = 12
) (
   // Clock
   input wire logic sys_clk_i,
   // Write port
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   // Read port
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);

   logic [WIDTH-1:0] mem_q [DEPTH];

   if (DEPTH != (1 << AW)) begin : g_bad_depth
      $error("prl_mem depth must fill the address range");
   end

   // Write and registered read
   always_ff @(posedge sys_clk_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_q[rd_addr_i];
   end

endmodule // prl_mem

`default_nettype wire

//--- bench/prl_eeprom_model.sv
// Behavioural serial EEPROM that answers the loader's read sequence
`timescale 1ns/1ps
`default_nettype none

module prl_eeprom_model #(
   parameter int SIZE = 64
) (
   // Bus wires
   input wire logic scl_i,
   input wire logic sda_i,
   // Pull-down enable of the data wire
   output logic sda_oe_o,
   // Fault injection: refuse the device address
   input wire logic nack_dev_i
);
   logic [7:0] mem [SIZE]; // Room beyond the image
   logic [7:0] sh = 8'h00;
   logic [15:0] ptr = 16'h0000;
   int bitn = 0;
   int idx = 0;
   logic tx = 1'b0;
   logic acking = 1'b0;
   logic to_tx = 1'b0;
   logic busy = 1'b0;

   initial sda_oe_o = 1'b0;

   // Start: data falls while the clock is high
   always @(negedge sda_i) begin
      if (scl_i === 1'b1) begin
         busy = 1'b1;
         tx = 1'b0;
         acking = 1'b0;
         bitn = 0;
         idx = 0;
      end
   end

   // Stop: data rises while the clock is high, the wire is let go
   always @(posedge sda_i) begin
      if (scl_i === 1'b1) begin
         busy = 1'b0;
         sda_oe_o = 1'b0;
      end
   end

   // Sample written bits, or the master's answer after a read byte
   always @(posedge scl_i) begin
      if (busy && !tx && bitn < 8) begin
         sh = {sh[6:0], sda_i};
         bitn = bitn + 1;
      end else if (busy && tx) begin
         if (bitn < 8) begin
            bitn = bitn + 1;
         end else if (sda_i === 1'b0) begin
            ptr = ptr + 16'h0001; // Bytes follow in address order
            bitn = 0;
         end else begin
            busy = 1'b0;
         end
      end
   end

   // Change the data wire only while the clock is low
   always @(negedge scl_i) begin
      if (busy && !tx && bitn == 8 && !acking) begin
         acking = 1'b1;
         if (idx == 0) begin
            to_tx = sh[0];
            sda_oe_o = (sh[7:1] == prl_pkg::EE_DEV_ADDR) && !nack_dev_i;
            busy = sda_oe_o;
         end else begin
            ptr = {ptr[7:0], sh}; // Two address bytes, high first
            to_tx = 1'b0;
            sda_oe_o = 1'b1;
         end
         idx = idx + 1;
      end else if (busy && acking) begin
         acking = 1'b0;
         bitn = 0;
         tx = to_tx;
         sda_oe_o = to_tx ? !mem[ptr][7] : 1'b0;
      end else if (busy && tx) begin
         sda_oe_o = (bitn < 8) ? !mem[ptr][7 - bitn] : 1'b0;
      end
   end
endmodule // prl_eeprom_model

`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the program store loader
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam int W = 16;
   localparam int NB = 2 * W + 1;
   logic sys_clk = 1'b0;
   logic rstn;
   logic reload;
   logic nack_dev;
   logic [11:0] fetch_addr;
   logic [3:0] irq_num;
   logic scl;
   logic sda_oe;
   logic sda_out;
   logic ee_oe;
   logic load_err;
   logic sys_reset;
   logic cpu_run;
   logic [11:0] fetch_data;
   logic [11:0] boot_addr;
   logic [11:0] vec_addr;
   logic [11:0] img [W];
   wire sda_w;
   int mismatches = 0;
   int num_checks = 0;

   // Clock and pulled-up data wire
   always #5 sys_clk = ~sys_clk;
   assign sda_w = ee_oe ? 1'b0 : (sda_oe ? sda_out : 1'b1);

   prl_loader #(.WORDS(W), .QUARTER_CYC(4)) prl_loader_inst (
      .sys_clk_i(sys_clk), .rstn_i(rstn), .reload_start_in_i(reload),
      .scl_o(scl), .sda_i(sda_w), .sda_o(sda_out), .sda_oe_o(sda_oe),
      .load_err_o(load_err), .sys_reset_o(sys_reset),
      .cpu_run_o(cpu_run), .fetch_addr_i(fetch_addr),
      .fetch_data_o(fetch_data), .boot_addr_o(boot_addr),
      .irq_num_i(irq_num), .vec_addr_o(vec_addr));

   prl_eeprom_model #(.SIZE(64)) prl_eeprom_model_inst (
      .scl_i(scl), .sda_i(sda_w), .sda_oe_o(ee_oe), .nack_dev_i(nack_dev));

   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Compare a word
   task automatic cmp12(input logic [11:0] got, input logic [11:0] exp,
                        input string what);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Compare a flag
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   // Expected vector address of an interrupt number
   function automatic logic [11:0] exp_vec(input logic [3:0] n);
      return {prl_pkg::VEC_PAGE, 4'h0, (n == 4'h0) ? 4'h1 : n};
   endfunction

   // Random image; fault 1 spoils the sum, fault 2 a pad nibble
   task automatic make_image(input int fault);
      logic [7:0] sum;
      sum = 8'h00;
      for (int k = 0; k < W; k++) begin
         img[k] = 12'($urandom);
         prl_eeprom_model_inst.mem[2*k] = {4'h0, img[k][11:8]};
         prl_eeprom_model_inst.mem[2*k+1] = img[k][7:0];
         sum = sum + {4'h0, img[k][11:8]} + img[k][7:0];
      end
      prl_eeprom_model_inst.mem[NB-1] = (8'h00 - sum) ^ 8'(fault == 1);
      if (fault == 2) prl_eeprom_model_inst.mem[2][4] = 1'b1;
   endtask

   // Wait for the load to end, random fetch traffic meanwhile
   task automatic run_load(input logic bad, input string name);
      int n;
      int edges;
      logic held;
      logic prev;
      n = 0;
      edges = 0;
      held = 1'b1;
      prev = scl;
      while (cpu_run !== 1'b1 && load_err !== 1'b1 && n < 40000) begin
         @(negedge sys_clk);
         fetch_addr = 12'($urandom);
         irq_num = 4'($urandom);
         if (cpu_run !== 1'b1 && load_err !== 1'b1 && sys_reset !== 1'b1)
            held = 1'b0;
         if (scl === 1'b1 && prev === 1'b0) edges++;
         prev = scl;
         n++;
      end
      cmp_bit(n < 40000, 1'b1, "load never ended");
      cmp_bit(held, 1'b1, "chip left reset during load");
      cmp_bit(edges > 8, 1'b1, "link clock idle");
      @(negedge sys_clk);
      cmp_bit(load_err, bad, "error pin");
      cmp_bit(cpu_run, !bad, "cpu run");
      cmp_bit(sys_reset, bad, "system reset");
      cmp_bit(scl, 1'b1, "link clock not idle high");
      $display("test %s done", name);
   endtask

   // Read back every word of the image
   task automatic check_store();
      for (int k = 0; k < W; k++) begin
         @(negedge sys_clk);
         fetch_addr = 12'(k);
         @(negedge sys_clk);
         cmp12(fetch_data, img[k], "fetch word");
      end
   endtask

   // Reload pulse: the chip goes back into reset on the third clock after it rises
   task automatic pulse_reload();
      @(negedge sys_clk);
      reload = 1'b1;
      repeat (6) @(negedge sys_clk);
      reload = 1'b0;
      cmp_bit(cpu_run, 1'b0, "reload ignored");
      cmp_bit(load_err, 1'b0, "error kept on reload");
      cmp_bit(sys_reset, 1'b1, "no reset on reload");
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'h3118));
      rstn = 1'b0;
      reload = 1'b0;
      nack_dev = 1'b0;
      fetch_addr = 12'h000;
      irq_num = 4'h0;
      make_image(0);
      repeat (16) @(negedge sys_clk);
      rstn = 1'b1;
      run_load(1'b0, "power_on");
      check_store();
      cmp12(boot_addr, 12'h100, "boot address");
      fetch_addr = 12'hfff;
      @(negedge sys_clk);
      cmp12(fetch_data, 12'h000, "top word not cleared");
      for (int i = 0; i < 16; i++) begin
         @(negedge sys_clk);
         irq_num = 4'(i);
         @(negedge sys_clk);
         cmp12(vec_addr, exp_vec(4'(i)), "vector");
      end
      make_image(0);
      pulse_reload();
      run_load(1'b0, "reload");
      check_store();
      make_image(1);
      pulse_reload();
      run_load(1'b1, "bad_sum");
      make_image(2);
      pulse_reload();
      run_load(1'b1, "bad_pad");
      fetch_addr = 12'(W - 1);
      @(negedge sys_clk);
      cmp12(fetch_data, 12'h000, "store not cleared");
      make_image(0);
      nack_dev = 1'b1;
      pulse_reload();
      run_load(1'b1, "no_answer");
      nack_dev = 1'b0;
      pulse_reload();
      run_load(1'b0, "recover");
      check_store();
      make_image(0);
      pulse_reload();
      repeat (2000) @(negedge sys_clk);
      rstn = 1'b0;
      repeat (16) @(negedge sys_clk);
      cmp_bit(sys_reset, 1'b1, "reset held");
      cmp_bit(scl, 1'b1, "clock idle in reset");
      rstn = 1'b1;
      run_load(1'b0, "reset_mid_load");
      check_store();
      end_sim();
   end

   // Watchdog against a hang
   initial begin
      #900000;
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      end_sim();
   end
endmodule // tb_top

`default_nettype wire
